// ---- rtl/fps_cfg.svh ----
`ifndef FPS_CFG_SVH
`define FPS_CFG_SVH
`define FPS_CLK_MHZ 50
`define FPS_START_PW_NS 200
`define FPS_END_PW_NS 8000
`define FPS_TD_NS 1800
`define FPS_CYC_NS 10000
`define FPS_HOLD_NS 100
`define FPS_SETUP_NS 0
`define FPS_VER_PCT 90
`define FPS_FINAL_US 2500
`define FPS_RAMP4_MS 180
`define FPS_RAMP8_MS 360
`define FPS_ABORT_MS 800
`define FPS_VER_NEED 128
`define FPS_S_START_NS 1000
`define FPS_S_END_NS 8000
`define FPS_S_RAMP_MS 100
`define FPS_S_GIVEUP_MS 400
`define FPS_S_TAIL_US 500
`define FPS_HALF_MASK 8'h0f
`define FPS_FULL_MASK 8'hff
`define FPS_ONE 8'h01
`endif

// ---- rtl/fps_pkg.sv ----
package fps_pkg;
	typedef enum logic [3:0] {
		S_IDLE, S_PULSE, S_HOLD, S_GAP, S_WAIT, S_FINAL, S_FHOLD,
		S_SHI, S_SLO, S_DONE, S_FAIL
	} fps_state_t;
	typedef struct packed {
		fps_state_t st;
		logic [8:0] pw;
		logic [8:0] wl;
		logic [17:0] ph;
		logic [9:0] cyc;
		logic [25:0] tot;
		logic [15:0] stp;
		logic [14:0] tail;
		logic [2:0] slot;
		logic single;
		logic [7:0] act;
		logic [7:0] seen;
		logic [7:0][7:0] vcnt;
		logic blown;
		logic vcc;
		logic cs;
		logic [7:0] src;
		logic [7:0] low;
	} fps_regs_t;
endpackage

// ---- rtl/fps_seq.sv ----
`include "fps_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module fps_seq import fps_pkg::*; #(
	parameter int RAMP4_CYC = `FPS_RAMP4_MS * 1000 * `FPS_CLK_MHZ,
	parameter int RAMP8_CYC = `FPS_RAMP8_MS * 1000 * `FPS_CLK_MHZ,
	parameter int FINAL_CYC = `FPS_FINAL_US * `FPS_CLK_MHZ,
	parameter int ABORT_CYC = `FPS_ABORT_MS * 1000 * `FPS_CLK_MHZ,
	parameter int SRAMP_CYC = `FPS_S_RAMP_MS * 1000 * `FPS_CLK_MHZ,
	parameter int GIVEUP_CYC = `FPS_S_GIVEUP_MS * 1000 * `FPS_CLK_MHZ,
	parameter int TAIL_CYC = `FPS_S_TAIL_US * `FPS_CLK_MHZ
) (
	// Clock, reset, enable
	input wire logic core_clk_in,
	input wire logic resetn_in,
	input wire logic clk_en_in,
	// Job request
	input wire logic start_in,
	input wire logic single_in,
	input wire logic wide_in,
	input wire logic [7:0] mask_in,
	input wire logic [2:0] sel_in,
	// Sensed PROM outputs
	input wire logic [7:0] sense_in,
	// Pulse generator and current sources
	output logic vcc_pulse_out,
	output logic cs_pulse_out,
	output logic [7:0] src_en_out,
	output logic [7:0] hold_low_out,
	// Status
	output logic busy_out,
	output logic done_out,
	output logic fail_out
);

	function automatic int up_cyc(input int ns);
		return (ns * `FPS_CLK_MHZ + 999) / 1000;
	endfunction

	function automatic logic [7:0] onehot(input logic [2:0] i);
		return `FPS_ONE << i;
	endfunction

	function automatic logic [2:0] next_slot(input logic [7:0] a,
			input logic [2:0] cur);
		logic [2:0] res;
		res = cur;
		for (int k = 8; k >= 1; k--) begin
			if (a[cur + 3'(k)])
				res = cur + 3'(k);
		end
		return res;
	endfunction

	localparam int ST_I = up_cyc(`FPS_START_PW_NS);
	localparam int EN_I = `FPS_END_PW_NS * `FPS_CLK_MHZ / 1000;
	localparam int TD_I = up_cyc(`FPS_TD_NS);
	localparam int SST_I = up_cyc(`FPS_S_START_NS);
	localparam int SEN_I = `FPS_S_END_NS * `FPS_CLK_MHZ / 1000;
	localparam logic [8:0] ST_W = 9'(ST_I);
	localparam logic [8:0] EN_W = 9'(EN_I);
	localparam logic [8:0] SST_W = 9'(SST_I);
	localparam logic [8:0] SEN_W = 9'(SEN_I);
	localparam logic [17:0] TD_C = 18'(TD_I);
	localparam logic [17:0] HOLD_C = 18'(up_cyc(`FPS_HOLD_NS));
	localparam logic [17:0] VER_C =
		18'((TD_I * `FPS_VER_PCT + 99) / 100);
	localparam logic [17:0] FIN_C = 18'(FINAL_CYC);
	localparam logic [9:0] CYC_C = 10'(up_cyc(`FPS_CYC_NS));
	localparam logic [25:0] ABORT_C = 26'(ABORT_CYC);
	localparam logic [25:0] GIVEUP_C = 26'(GIVEUP_CYC);
	localparam logic [14:0] TAIL_C = 15'(TAIL_CYC);
	localparam logic [7:0] NEED_C = 8'(`FPS_VER_NEED);
	localparam logic [15:0] STEP4_C = 16'(RAMP4_CYC / (EN_I - ST_I));
	localparam logic [15:0] STEP8_C = 16'(RAMP8_CYC / (EN_I - ST_I));
	localparam logic [15:0] SSTEP_C = 16'(SRAMP_CYC / (SEN_I - SST_I));

	fps_regs_t r_reg, r_next;

	logic [7:0] ok;
	logic all_seen;
	logic all_full;
	logic ramp_st;
	logic slow_st;
	logic [15:0] step_c;
	logic [8:0] end_w;
	logic [2:0] nx;

	always_comb begin
		r_next = r_reg;
		for (int i = 0; i < 8; i++)
			ok[i] = !r_reg.act[i] || (r_reg.vcnt[i] >= NEED_C);
		all_seen = &(r_reg.seen | ~r_reg.act);
		all_full = &ok;
		ramp_st = r_reg.st inside {S_PULSE, S_HOLD, S_GAP, S_WAIT};
		slow_st = r_reg.st inside {S_SHI, S_SLO};
		nx = next_slot(r_reg.act, r_reg.slot);
		if (r_reg.single) begin
			step_c = SSTEP_C;
			end_w = SEN_W;
		end else begin
			step_c = wide_in ? STEP8_C : STEP4_C;
			end_w = EN_W;
		end

		// Width ramp: one cycle wider every step_c cycles, then clamp
		if (ramp_st || slow_st) begin
			r_next.tot = r_reg.tot + 26'd1;
			if (r_reg.stp >= step_c - 16'd1) begin
				r_next.stp = '0;
				if (r_reg.pw < end_w)
					r_next.pw = r_reg.pw + 9'd1;
			end else begin
				r_next.stp = r_reg.stp + 16'd1;
			end
		end
		if (ramp_st && r_reg.cyc < CYC_C)
			r_next.cyc = r_reg.cyc + 10'd1;

		case (r_reg.st)
			S_IDLE, S_DONE, S_FAIL: begin
				if (start_in) begin
					r_next = '0;
					r_next.single = single_in;
					if (single_in) begin
						r_next.slot = sel_in;
						r_next.act = onehot(sel_in);
						r_next.pw = SST_W;
						r_next.wl = SST_W;
						r_next.st = S_SHI;
					end else begin
						r_next.act = mask_in &
							(wide_in ? `FPS_FULL_MASK : `FPS_HALF_MASK);
						r_next.pw = ST_W;
						r_next.wl = ST_W;
						r_next.slot = next_slot(r_next.act, 3'h7);
						r_next.st = (r_next.act == 8'h00) ? S_DONE : S_PULSE;
					end
				end
			end
			S_PULSE: begin
				r_next.ph = r_reg.ph + 18'd1;
				if (r_reg.ph == 18'(r_reg.wl) - 18'd1) begin
					r_next.ph = '0;
					r_next.st = S_HOLD;
				end
			end
			S_HOLD: begin
				r_next.ph = r_reg.ph + 18'd1;
				if (r_reg.ph == HOLD_C - 18'd1)
					r_next.st = S_GAP;
			end
			S_GAP: begin
				r_next.ph = r_reg.ph + 18'd1;
				// Programmed output reads low after select has dropped
				if (r_reg.ph == VER_C && !sense_in[r_reg.slot]) begin
					r_next.seen[r_reg.slot] = 1'b1;
					// Failures do not clear the count
					if (all_seen && r_reg.vcnt[r_reg.slot] < NEED_C)
						r_next.vcnt[r_reg.slot] =
							r_reg.vcnt[r_reg.slot] + 8'd1;
				end
				if (r_reg.ph == TD_C - 18'd1) begin
					r_next.ph = '0;
					r_next.slot = nx;
					r_next.wl = r_reg.pw;
					r_next.st = (nx <= r_reg.slot) ? S_WAIT : S_PULSE;
				end
			end
			S_WAIT: begin
				// Few outputs or narrow pulses would crowd one output
				if (r_reg.cyc >= CYC_C - 10'd1) begin
					r_next.cyc = '0;
					r_next.wl = r_reg.pw;
					r_next.st = all_full ? S_FINAL : S_PULSE;
				end
			end
			S_FINAL: begin
				r_next.ph = r_reg.ph + 18'd1;
				if (r_reg.ph == FIN_C - 18'd1) begin
					r_next.ph = '0;
					r_next.st = S_FHOLD;
				end
			end
			S_FHOLD: begin
				r_next.ph = r_reg.ph + 18'd1;
				if (r_reg.ph == HOLD_C - 18'd1)
					r_next.st = S_DONE;
			end
			S_SHI: begin
				r_next.ph = r_reg.ph + 18'd1;
				if (r_reg.ph == 18'(r_reg.wl) - 18'd1) begin
					r_next.ph = '0;
					r_next.st = S_SLO;
				end
			end
			S_SLO: begin
				r_next.ph = r_reg.ph + 18'd1;
				if (r_reg.ph == 18'(r_reg.wl) - 18'd1) begin
					r_next.ph = '0;
					r_next.wl = r_reg.pw;
					r_next.st = S_SHI;
					if (sense_in[r_reg.slot])
						r_next.blown = 1'b1;
					if (r_reg.blown && r_reg.tail >= TAIL_C)
						r_next.st = S_DONE;
				end
			end
			default: r_next.st = S_IDLE;
		endcase

		if (slow_st && r_reg.blown && r_reg.tail < TAIL_C)
			r_next.tail = r_reg.tail + 15'd1;
		// Give up only while supply and select are low, so hold is kept
		if (r_reg.st inside {S_GAP, S_WAIT} && r_reg.tot >= ABORT_C)
			r_next.st = S_FAIL;
		if (r_reg.st == S_SLO && !r_reg.blown && r_reg.tot >= GIVEUP_C)
			r_next.st = S_FAIL;

		// Select rises on the same edge as the supply pulse
		r_next.vcc = r_next.st inside {S_PULSE, S_FINAL, S_SHI};
		r_next.cs = r_next.vcc ||
			(r_next.st inside {S_HOLD, S_FHOLD});
		if (r_next.st inside {S_PULSE, S_HOLD})
			r_next.src = onehot(r_next.slot);
		else if (r_next.st inside {S_FINAL, S_FHOLD, S_SHI, S_SLO})
			r_next.src = r_next.act;
		else
			r_next.src = 8'h00;
		r_next.low = (r_next.st inside {S_SHI, S_SLO}) ?
			~r_next.act : 8'h00;
	end

	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in)
			r_reg <= '0;
		else if (clk_en_in)
			r_reg <= r_next;
	end

	assign vcc_pulse_out = r_reg.vcc;
	assign cs_pulse_out = r_reg.cs;
	assign src_en_out = r_reg.src;
	assign hold_low_out = r_reg.low;
	assign done_out = (r_reg.st == S_DONE);
	assign fail_out = (r_reg.st == S_FAIL);
	assign busy_out = !(r_reg.st inside {S_IDLE, S_DONE, S_FAIL});

endmodule
`default_nettype wire

// ---- verif/fps_seq_checker.sv ----
`timescale 1ns/100ps
`default_nettype none
module fps_seq_checker (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic resetn_in,
	// Watched outputs
	input wire logic vcc_pulse_out,
	input wire logic cs_pulse_out,
	input wire logic [7:0] src_en_out,
	input wire logic [7:0] hold_low_out,
	input wire logic busy_out,
	input wire logic done_out,
	input wire logic fail_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!resetn_in);
	// Word mode never holds outputs low
	wire logic ramp = hold_low_out == 8'h00;
	sequence start_w_s;
		vcc_pulse_out[*5] ##1 vcc_pulse_out[*5] ##1 !vcc_pulse_out;
	endsequence
	sequence hold_s;
		cs_pulse_out[*5] ##1 !cs_pulse_out;
	endsequence
	start_width_a: assert property (
		$rose(busy_out) && vcc_pulse_out && ramp |-> start_w_s)
		else $error("first pulse width wrong");
	select_setup_a: assert property (
		$rose(vcc_pulse_out) |-> cs_pulse_out)
		else $error("select late on supply rise");
	select_hold_a: assert property (
		$fell(vcc_pulse_out) && ramp |-> hold_s)
		else $error("select hold wrong");
	output_gap_a: assert property (
		$fell(cs_pulse_out) && ramp && busy_out |-> (!vcc_pulse_out)[*8])
		else $error("next output pulsed too soon");
	single_shape_a: assert property (
		vcc_pulse_out && !ramp |-> $onehot(src_en_out)
		&& (src_en_out & hold_low_out) == 8'h00 && cs_pulse_out)
		else $error("single mode drive wrong");
	single_width_a: assert property (
		$rose(vcc_pulse_out) && !ramp |-> vcc_pulse_out[*8])
		else $error("single pulse too short");
	idle_quiet_a: assert property (
		!busy_out |-> !vcc_pulse_out && !cs_pulse_out
		&& src_en_out == 8'h00)
		else $error("pulse while idle");
	status_excl_a: assert property (
		!(done_out && fail_out))
		else $error("done and fail together");
endmodule
bind fps_seq fps_seq_checker chk (
	.core_clk_in(core_clk_in),
	.resetn_in(resetn_in),
	.vcc_pulse_out(vcc_pulse_out),
	.cs_pulse_out(cs_pulse_out),
	.src_en_out(src_en_out),
	.hold_low_out(hold_low_out),
	.busy_out(busy_out),
	.done_out(done_out),
	.fail_out(fail_out)
);
`default_nettype wire

// ---- verif/fps_prom_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module fps_prom_model #(
	parameter logic [7:0] STUCK = 8'h80,
	parameter int BLOW = 3
) (
	// Pulse generator side
	input wire logic vcc_in,
	input wire logic cs_in,
	input wire logic [7:0] src_in,
	input wire logic [7:0] low_in,
	// Sensed outputs
	output logic [7:0] sense_out
);
	int hits [8];
	logic [7:0] blown = 8'h00;
	logic [7:0] pat = 8'h55;
	// Fuses survive reset, as real silicon does
	// Count on the falling edge: src changes together with the rising one
	always @(negedge vcc_in) begin
		pat <= ~pat;
		for (int i = 0; i < 8; i++) begin
			if (src_in[i] && !STUCK[i]) begin
				hits[i] = hits[i] + 1;
				if (hits[i] >= BLOW) blown[i] <= 1'b1;
			end
		end
	end
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (low_in[i]) sense_out[i] = 1'b0;
			else if (cs_in) sense_out[i] = pat[i];
			else if (low_in != 8'h00) sense_out[i] = blown[i];
			else sense_out[i] = !blown[i];
		end
	end
endmodule
`default_nettype wire

// ---- verif/fps_seq_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module fps_seq_tb_top;
	import fps_pkg::*;
	typedef struct packed {
		logic single;
		logic wide;
		logic [7:0] mask;
		logic [2:0] sel;
		logic [1:0] res;
	} fps_row_t;
	logic core_clk_in, resetn_in, clk_en_in, start_in, single_in, wide_in;
	logic [7:0] mask_in, sense_in, src_en_out, hold_low_out;
	logic [2:0] sel_in;
	logic vcc_pulse_out, cs_pulse_out, busy_out, done_out, fail_out;
	int err_count = 0;
	int check_count = 0;
	fps_row_t rows [4] = '{'{1'b0, 1'b0, 8'hf1, 3'd0, 2'b10},
		'{1'b0, 1'b1, 8'h00, 3'd0, 2'b10},
		'{1'b1, 1'b0, 8'h00, 3'd3, 2'b10},
		'{1'b1, 1'b0, 8'h00, 3'd7, 2'b01}};
	logic [15:0] snap;
	fps_seq #(.RAMP4_CYC(3900), .FINAL_CYC(200), .SRAMP_CYC(3500),
		.GIVEUP_CYC(3000), .TAIL_CYC(300)) uut (.core_clk_in(core_clk_in),
		.resetn_in(resetn_in), .clk_en_in(clk_en_in),
		.start_in(start_in), .single_in(single_in), .wide_in(wide_in),
		.mask_in(mask_in), .sel_in(sel_in), .sense_in(sense_in),
		.vcc_pulse_out(vcc_pulse_out), .cs_pulse_out(cs_pulse_out),
		.src_en_out(src_en_out), .hold_low_out(hold_low_out),
		.busy_out(busy_out), .done_out(done_out), .fail_out(fail_out));
	fps_prom_model prom (.vcc_in(vcc_pulse_out), .cs_in(cs_pulse_out),
		.src_in(src_en_out), .low_in(hold_low_out), .sense_out(sense_in));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		$display("Checks made %0d, mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic launch(input fps_row_t r);
		single_in <= r.single;
		wide_in <= r.wide;
		mask_in <= r.mask;
		sel_in <= r.sel;
		start_in <= 1'b1;
		@(posedge core_clk_in);
		start_in <= 1'b0;
	endtask
	task automatic finish_job(input logic [1:0] res);
		int n;
		n = 0;
		do @(negedge core_clk_in);
		while (busy_out !== 1'b0 && n++ < 90000);
		check({14'h0, done_out, fail_out}, {14'h0, res});
		@(posedge core_clk_in);
	endtask
	initial begin
		core_clk_in = 1'b0;
		forever #10 core_clk_in = ~core_clk_in;
	end
	// Sized for one full word job plus the short single jobs
	initial begin
		repeat (95000) @(posedge core_clk_in);
		err_count++;
		end_of_test();
	end
	initial begin
		{resetn_in, start_in, single_in, wide_in} = 4'h0;
		clk_en_in = 1'b1;
		mask_in = 8'h00;
		sel_in = 3'd0;
		repeat (12) @(posedge core_clk_in);
		resetn_in <= 1'b1;
		foreach (rows[i]) begin
			launch(rows[i]);
			finish_job(rows[i].res);
		end
		launch('{1'b1, 1'b0, 8'h00, 3'd4, 2'b10});
		repeat (20) @(posedge core_clk_in);
		clk_en_in <= 1'b0;
		@(negedge core_clk_in);
		snap = {7'h0, vcc_pulse_out, src_en_out};
		repeat (40) @(posedge core_clk_in);
		check({7'h0, vcc_pulse_out, src_en_out}, snap);
		clk_en_in <= 1'b1;
		launch('{1'b1, 1'b0, 8'h00, 3'd5, 2'b10});
		@(negedge core_clk_in);
		check({8'h0, hold_low_out}, 16'h00ef);
		finish_job(2'b10);
		launch('{1'b1, 1'b0, 8'h00, 3'd5, 2'b10});
		repeat (30) @(posedge core_clk_in);
		resetn_in <= 1'b0;
		@(negedge core_clk_in);
		check({src_en_out, vcc_pulse_out, cs_pulse_out, busy_out,
			done_out, fail_out, 3'h0}, 16'h0000);
		@(posedge core_clk_in);
		resetn_in <= 1'b1;
		repeat (2) @(negedge core_clk_in);
		check({13'h0, busy_out, done_out, fail_out}, 16'h0000);
		end_of_test();
	end
endmodule
`default_nettype wire
